//--- core/qwr_device_fsm.sv
/*
 * Device-side command engine for a queued DMA write, with the receive
 * buffer that sits between the transport layer and the device store.
 * Assumes one clock, a transport layer that holds fis_tx_done for one
 * cycle per sent FIS, and that the host has set up its DMA engine.
 */
`timescale 1ns/1ps

// ==============================================================
// Receive buffer
module rx_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_q];

    AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_q <= (AW+1)'(DEPTH))
        else $error("receive buffer count beyond depth");
    AST_FIFO_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("buffered word changed before it was taken");

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : rx_fifo

// ==============================================================
// Command engine
module qwr_device_fsm #(
    parameter int DEPTH = qwr_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire qwr_pkg::cmd_type cmd,
    input wire logic dev_can_accept,
    input wire logic dev_error,
    input wire logic rel_irq_en,
    output logic fis_tx_req,
    output qwr_pkg::tx_fis_type fis_tx,
    input wire logic fis_tx_done,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic [qwr_pkg::DATA_W-1:0] rx_data,
    input wire logic rx_last,
    output logic buf_valid,
    input wire logic buf_ready,
    output logic [qwr_pkg::DATA_W-1:0] buf_data,
    output logic busy
);
    import qwr_pkg::*;

    state_type state_q;
    state_type state_d;
    logic [REM_W-1:0] rem_q;
    logic [TAG_W-1:0] tag_q;
    logic err_q;
    logic irq_en_q;
    logic abort;
    logic all_done;
    logic fifo_in_ready;
    logic rx_take;
    logic cmd_take;
    logic begun_q;

    assign cmd_ready = (state_q == device_idle_state);
    assign cmd_take = cmd_valid && cmd_ready;
    assign busy = !cmd_ready;
    assign abort = err_q || dev_error;
    assign all_done = (rem_q == '0);
    assign rx_ready = (state_q == qwr_receive_state) && fifo_in_ready;
    assign rx_take = rx_valid && rx_ready;
    assign fis_tx_req = (state_q == qwr_activate_state)
        || (state_q == qwr_status_state) || (state_q == qwr_release_state);

    // ==========================================================
    // Receive buffer toward the device store
    rx_fifo #(.WIDTH(DATA_W), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rst_n(rst_n),
        .in_valid(rx_valid && (state_q == qwr_receive_state)),
        .in_ready(fifo_in_ready),
        .in_data(rx_data),
        .out_valid(buf_valid),
        .out_ready(buf_ready),
        .out_data(buf_data)
    );

    // ==========================================================
    // Next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            device_idle_state: begin
                if (cmd_take) begin
                    state_d = qwr_decide_state;
                end
            end
            qwr_decide_state: begin
                if (abort || all_done) begin
                    state_d = qwr_status_state;
                end else if (dev_can_accept) begin
                    state_d = qwr_activate_state;
                end else begin
                    state_d = qwr_release_state;
                end
            end
            qwr_activate_state: begin
                if (fis_tx_done) begin
                    state_d = qwr_receive_state;
                end
            end
            qwr_receive_state: begin
                if (rx_take && rx_last) begin
                    state_d = qwr_buffer_prep_state;
                end
            end
            qwr_buffer_prep_state: begin
                // Waits here rather than releasing once data has moved
                if (abort || all_done) begin
                    state_d = qwr_status_state;
                end else if (dev_can_accept) begin
                    state_d = qwr_activate_state;
                end
            end
            qwr_status_state, qwr_release_state: begin
                if (fis_tx_done) begin
                    state_d = device_idle_state;
                end
            end
            default: begin
                state_d = device_idle_state;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= device_idle_state;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Command context
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rem_q <= REM_RESET;
            tag_q <= '0;
            irq_en_q <= 1'b0;
        end else if (cmd_take) begin
            rem_q <= REM_W'({cmd.sectors, {SECT_SHIFT{1'b0}}});
            tag_q <= cmd.tag;
            irq_en_q <= rel_irq_en;
        end else if (rx_take && !all_done) begin
            rem_q <= rem_q - 1'b1;
        end
    end

    // Error is sticky for the command; idle holds no error source
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else if (dev_error && busy) begin
            err_q <= 1'b1;
        end else if (cmd_take) begin
            err_q <= 1'b0;
        end
    end

    // Set once the first word of a command lands; AST_NO_REL_BEGUN checks that no release follows it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            begun_q <= 1'b0;
        end else if (rx_take) begin
            begun_q <= 1'b1;
        end else if (cmd_take) begin
            begun_q <= 1'b0;
        end
    end

    // ==========================================================
    // Outgoing FIS content, loaded for the state being entered and held while it is requested
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fis_tx <= '0;
        end else if (state_d != state_q) begin
            fis_tx.tag <= tag_q;
            fis_tx.fis_type <= FIS_REG_D2H;
            fis_tx.rel <= 1'b0;
            fis_tx.irq <= 1'b0;
            fis_tx.status <= STATUS_GOOD;
            fis_tx.error <= ERROR_NONE;
            case (state_d)
                qwr_activate_state: begin
                    fis_tx.fis_type <= FIS_DMA_ACT;
                end
                qwr_status_state: begin
                    fis_tx.irq <= 1'b1;
                    if (abort) begin
                        fis_tx.status <= STATUS_FAIL;
                        fis_tx.error <= ERROR_ABORT;
                    end
                end
                qwr_release_state: begin
                    fis_tx.rel <= 1'b1;
                    fis_tx.irq <= irq_en_q;
                end
                default: begin
                    fis_tx.fis_type <= FIS_REG_D2H;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_CMD_DECIDE: assert property (cmd_take |=> state_q == qwr_decide_state)
        else $error("command accept did not enter decide");
    AST_DECIDE_ACT: assert property ((state_q == qwr_decide_state) && !abort
        && !all_done && dev_can_accept |=> state_q == qwr_activate_state)
        else $error("decide did not go to activate");
    AST_DECIDE_ABORT: assert property ((state_q == qwr_decide_state) && abort
        |=> state_q == qwr_status_state && fis_tx.status == STATUS_FAIL)
        else $error("decide abort did not go to status");
    AST_DECIDE_REL: assert property ((state_q == qwr_decide_state) && !abort
        && !all_done && !dev_can_accept |=> state_q == qwr_release_state)
        else $error("decide did not go to release");
    AST_ACT_REQ: assert property ((state_q == qwr_activate_state)
        |-> fis_tx_req && fis_tx.fis_type == FIS_DMA_ACT)
        else $error("activate FIS not requested");
    AST_ACT_DONE: assert property ((state_q == qwr_activate_state) && fis_tx_done
        |=> (state_q == qwr_receive_state) && !fis_tx_req)
        else $error("activate done did not enter receive");
    AST_RX_READY: assert property (rx_take
        |=> buf_valid)
        else $error("accepted word did not reach the buffer");
    AST_RX_LAST: assert property (rx_take && rx_last
        |=> state_q == qwr_buffer_prep_state)
        else $error("last word did not enter buffer prep");
    AST_PREP_ACT: assert property ((state_q == qwr_buffer_prep_state) && !abort
        && !all_done && dev_can_accept |=> state_q == qwr_activate_state)
        else $error("buffer prep did not solicit more data");
    AST_PREP_STATUS: assert property ((state_q == qwr_buffer_prep_state)
        && (abort || all_done) |=> state_q == qwr_status_state)
        else $error("buffer prep did not go to status");
    AST_STATUS_IRQ: assert property ((state_q == qwr_status_state)
        |-> fis_tx_req && fis_tx.irq && !fis_tx.rel)
        else $error("status FIS lacks interrupt bit");
    AST_BACK_IDLE: assert property (((state_q == qwr_status_state)
        || (state_q == qwr_release_state)) && fis_tx_done
        |=> cmd_ready ##1 !fis_tx_req)
        else $error("engine did not return to idle");
    AST_REL_BIT: assert property ((state_q == qwr_release_state)
        |-> fis_tx_req && fis_tx.rel && fis_tx.fis_type == FIS_REG_D2H)
        else $error("release FIS lacks release bit");
    AST_REL_IRQ: assert property ((state_q == qwr_release_state)
        |-> fis_tx.irq == irq_en_q)
        else $error("release interrupt bit wrong");
    AST_NO_REL_MID: assert property (($past(state_q) == qwr_buffer_prep_state)
        || ($past(state_q) == qwr_receive_state)
        |-> state_q != qwr_release_state)
        else $error("bus release after data began");
    AST_REM_COUNT: assert property (rx_take && !all_done && !cmd_take
        |=> rem_q == $past(rem_q) - 1'b1)
        else $error("outstanding count not decremented");
    AST_NO_REL_BEGUN: assert property (begun_q |-> state_q != qwr_release_state)
        else $error("bus release after first data word");
    AST_FIS_STABLE: assert property (fis_tx_req && !fis_tx_done
        |=> fis_tx_req && $stable(fis_tx))
        else $error("FIS content changed while requested");
    AST_IDLE_QUIET: assert property ((state_q == device_idle_state)
        |-> !fis_tx_req && !rx_ready)
        else $error("idle engine requests a FIS or data");
    AST_REM_LOAD: assert property (cmd_take
        |=> rem_q == REM_W'({$past(cmd.sectors), {SECT_SHIFT{1'b0}}}))
        else $error("outstanding count not loaded from command");

endmodule : qwr_device_fsm

//--- core/qwr_pkg.sv
/*
 * Shared constants and types for the queued DMA write command engine.
 * Assumes a device transport layer that sends FISes on request and
 * delivers received Data FIS payload as a stream of 32-bit words.
 */
package qwr_pkg;

    // ==========================================================
    // Widths and counts
    localparam int DATA_W = 32;
    localparam int TAG_W = 5;
    localparam int SECT_W = 16;
    localparam int REM_W = 23;
    localparam int SECT_SHIFT = 7;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // FIS codes and register content
    localparam logic [7:0] FIS_REG_D2H = 8'h34;
    localparam logic [7:0] FIS_DMA_ACT = 8'h39;
    localparam logic [7:0] STATUS_GOOD = 8'h50;
    localparam logic [7:0] STATUS_FAIL = 8'h51;
    localparam logic [7:0] ERROR_NONE = 8'h00;
    localparam logic [7:0] ERROR_ABORT = 8'h04;

    // ==========================================================
    // Reset values
    localparam logic [REM_W-1:0] REM_RESET = 23'h00_0000;

    // ==========================================================
    // Command engine states, one-hot
    typedef enum logic [6:0] {
        device_idle_state = 7'h01,
        qwr_decide_state = 7'h02,
        qwr_activate_state = 7'h04,
        qwr_receive_state = 7'h08,
        qwr_buffer_prep_state = 7'h10,
        qwr_status_state = 7'h20,
        qwr_release_state = 7'h40
    } state_type;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [TAG_W-1:0] tag;
        logic [SECT_W-1:0] sectors;
    } cmd_type;

    typedef struct packed {
        logic [7:0] fis_type;
        logic rel;
        logic irq;
        logic [7:0] status;
        logic [7:0] error;
        logic [TAG_W-1:0] tag;
    } tx_fis_type;

endpackage : qwr_pkg

//--- tb/qwr_transport_model.sv
/*
 * Transport layer stand-in for the queued write engine: answers FIS send
 * requests promptly and slowly by turns, and delivers one Data FIS after each DMA Activate FIS.
 * Assumes fis_tx_req and fis_tx hold until fis_tx_done.
 */
`timescale 1ns/1ps

module qwr_transport_model #(
    parameter int FIS_WORDS = 64
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic fis_tx_req,
    input wire qwr_pkg::tx_fis_type fis_tx,
    output logic fis_tx_done,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [qwr_pkg::DATA_W-1:0] rx_data,
    output logic rx_last
);
    import qwr_pkg::*;

    logic [1:0] wait_q;
    logic slow_q;
    logic [15:0] left_q;
    logic [DATA_W-1:0] word_q;
    logic take;

    assign take = fis_tx_req && !fis_tx_done && wait_q == 2'h0;

    // ==========================================================
    // FIS send answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fis_tx_done <= 1'h0;
            wait_q <= 2'h0;
            slow_q <= 1'h0;
        end else begin
            fis_tx_done <= take;
            if (take) begin
                slow_q <= ~slow_q;
                wait_q <= slow_q ? 2'h0 : 2'h3;
            end else if (fis_tx_req && !fis_tx_done) begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end

    // ==========================================================
    // Data FIS delivery, only once a DMA Activate FIS has been taken
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            left_q <= 16'h0000;
            word_q <= 32'hC0DE_0000;
        end else if (take && fis_tx.fis_type == FIS_DMA_ACT) begin
            left_q <= 16'(FIS_WORDS);
        end else if (rx_valid && rx_ready) begin
            left_q <= left_q - 16'h0001;
            word_q <= word_q + 32'h0000_0001;
        end
    end

    assign rx_valid = left_q != 16'h0000;
    assign rx_last = left_q == 16'h0001;
    assign rx_data = rx_valid ? word_q : ~word_q;

endmodule : qwr_transport_model

//--- tb/test_qwr_device_fsm.sv
/*
 * Self-checking bench for the queued write engine: expected FISes queue
 * up as commands start; a monitor checks each sent FIS and every word.
 * Assumes the transport model sends 64-word Data FISes from C0DE_0000.
 */
`timescale 1ns/1ps

module test_qwr_device_fsm;
    import qwr_pkg::*;

    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cmd_valid = 1'h0;
    logic cmd_ready;
    cmd_type cmd = '0;
    logic dev_can_accept = 1'h0;
    logic dev_error = 1'h0;
    logic rel_irq_en = 1'h0;
    logic fis_tx_req;
    tx_fis_type fis_tx;
    logic fis_tx_done;
    logic rx_valid;
    logic rx_ready;
    logic [DATA_W-1:0] rx_data;
    logic rx_last;
    logic buf_valid;
    logic buf_ready = 1'h0;
    logic [DATA_W-1:0] buf_data;
    logic busy;
    int err_count = 0;
    int n_tests = 0;
    int word_cnt = 0;
    logic [15:0] lfsr = 16'hBCF6;
    logic stall = 1'h0;
    logic [DATA_W-1:0] exp_word = 32'hC0DE_0000;
    tx_fis_type exp_q[$];

    always #20 clk = ~clk;

    qwr_device_fsm #(.DEPTH(FIFO_DEPTH)) qwr_device_fsm_inst (.clk, .rst_n, .cmd_valid,
        .cmd_ready, .cmd, .dev_can_accept, .dev_error, .rel_irq_en, .fis_tx_req, .fis_tx,
        .fis_tx_done, .rx_valid, .rx_ready, .rx_data, .rx_last, .buf_valid, .buf_ready,
        .buf_data, .busy);

    qwr_transport_model #(.FIS_WORDS(64)) qwr_transport_model_inst (.clk, .rst_n, .fis_tx_req,
        .fis_tx, .fis_tx_done, .rx_valid, .rx_ready, .rx_data, .rx_last);

    // ==========================================================
    // Checks and closing
    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_val

    task automatic cmp_fis(input tx_fis_type exp, input tx_fis_type got);
        n_tests++;
        if (exp.fis_type != FIS_REG_D2H || exp.rel) begin
            got.status = 8'h00;
            got.error = 8'h00;
        end
        if (got !== exp) begin
            err_count++;
            $display("BAD fis_tx expected %h seen %h", exp, got);
        end
    endtask : cmp_fis

    task automatic conclude();
        $display("Counts: %0d checks, %0d mismatches", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : conclude

    always @(posedge clk) begin
        if (rst_n && fis_tx_req && fis_tx_done) begin
            cmp_fis(exp_q.size() != 0 ? exp_q.pop_front() : '1, fis_tx);
        end
        if (rst_n && buf_valid && buf_ready) begin
            cmp_val("buf_data", exp_word, buf_data);
            exp_word++;
            word_cnt++;
        end
    end

    // ==========================================================
    // Stimulus
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : step

    always @(negedge clk) begin
        lfsr = step(lfsr);
        buf_ready = ~stall & (lfsr[0] | lfsr[1]);
    end

    function automatic tx_fis_type mk(input logic [7:0] t, input logic r, input logic i,
                                      input logic [7:0] s, input logic [7:0] e);
        return '{t, r, i, s, e, cmd.tag};
    endfunction : mk

    task automatic start(input logic [15:0] sec, input logic acc, input logic err,
                         input logic ien);
        @(negedge clk);
        cmp_val("cmd_ready", 32'h0000_0001, {31'h0, cmd_ready});
        cmd_valid = 1'h1;
        cmd = '{lfsr[4:0], sec};
        dev_can_accept = acc;
        dev_error = err;
        rel_irq_en = ien;
        word_cnt = 0;
        @(negedge clk);
        cmd_valid = 1'h0;
        cmp_val("busy", 32'h0000_0001, {31'h0, busy});
        cmp_val("cmd_ready", 32'h0000_0000, {31'h0, cmd_ready});
    endtask : start

    task automatic wait_until(input int words, input logic idle);
        int i;
        for (i = 0; i < 4000; i++) begin
            if (idle ? (busy === 1'h0 && exp_q.size() == 0 && buf_valid === 1'h0)
                : word_cnt >= words) break;
            @(negedge clk);
        end
        if (i == 4000) begin
            err_count++;
            $display("BAD wait expected done seen timeout");
            conclude();
        end
    endtask : wait_until

    initial begin
        repeat (8) @(negedge clk);
        rst_n = 1'h1;
        stall = 1'h1;
        start(16'h0001, 1'h1, 1'h0, 1'h0);
        exp_q.push_back(mk(FIS_DMA_ACT, 1'h0, 1'h0, 8'h00, 8'h00));
        repeat (40) @(negedge clk);
        cmp_val("rx_ready", 32'h0000_0000, {31'h0, rx_ready});
        stall = 1'h0;
        exp_q.push_back(mk(FIS_DMA_ACT, 1'h0, 1'h0, 8'h00, 8'h00));
        exp_q.push_back(mk(FIS_REG_D2H, 1'h0, 1'h1, STATUS_GOOD, ERROR_NONE));
        wait_until(0, 1'h1);
        cmp_val("word count", 32'h0000_0080, 32'(word_cnt));
        $display("Test done: two Data FIS write");
        for (int k = 0; k < 2; k++) begin
            start(16'h0004, 1'h0, 1'h0, k[0]);
            exp_q.push_back(mk(FIS_REG_D2H, 1'h1, k[0], 8'h00, 8'h00));
            wait_until(0, 1'h1);
            cmp_val("word count", 32'h0000_0000, 32'(word_cnt));
        end
        $display("Test done: bus release");
        start(16'h0000, 1'h1, 1'h0, 1'h0);
        exp_q.push_back(mk(FIS_REG_D2H, 1'h0, 1'h1, STATUS_GOOD, ERROR_NONE));
        wait_until(0, 1'h1);
        cmp_val("word count", 32'h0000_0000, 32'(word_cnt));
        $display("Test done: empty command");
        start(16'h0002, 1'h1, 1'h1, 1'h0);
        exp_q.push_back(mk(FIS_REG_D2H, 1'h0, 1'h1, STATUS_FAIL, ERROR_ABORT));
        wait_until(0, 1'h1);
        dev_error = 1'h0;
        $display("Test done: abort at decide");
        start(16'h0001, 1'h1, 1'h0, 1'h1);
        exp_q.push_back(mk(FIS_DMA_ACT, 1'h0, 1'h0, 8'h00, 8'h00));
        wait_until(1, 1'h0);
        dev_can_accept = 1'h0;
        wait_until(64, 1'h0);
        repeat (20) @(negedge clk);
        cmp_val("busy", 32'h0000_0001, {31'h0, busy});
        exp_q.push_back(mk(FIS_REG_D2H, 1'h0, 1'h1, STATUS_FAIL, ERROR_ABORT));
        dev_error = 1'h1;
        wait_until(0, 1'h1);
        dev_error = 1'h0;
        cmp_val("word count", 32'h0000_0040, 32'(word_cnt));
        $display("Test done: abort mid transfer");
        conclude();
    end

endmodule : test_qwr_device_fsm
